//--- opp_cfg.svh
`ifndef OPP_CFG_SVH
`define OPP_CFG_SVH

// ************************************************************
// access-select codes {access_select_hi, access_select_lo}
// ************************************************************
`define OPP_SEL_RESERVED 2'h0
`define OPP_SEL_IDENT    2'h1
`define OPP_SEL_LOCK     2'h2
`define OPP_SEL_MEMORY   2'h3

// ************************************************************
// identification byte addresses and lock field positions
// ************************************************************
`define OPP_IDENT_ADDR0  8'hfc
`define OPP_IDENT_ADDR1  8'hfd
`define OPP_IDENT_ADDR2  8'hfe
`define OPP_LOCK_BIT_HI  1
`define OPP_LOCK_BIT_LO  0
`define OPP_LOCK_RESET   2'h3
`define OPP_ERASED_BYTE  8'hff

// ************************************************************
// widths
// ************************************************************
`define OPP_ADDR_W       14
`define OPP_HI_ADDR_W    6

`endif

//--- opp_pkg.sv
package opp_pkg;

  // protection levels, coded as the lock value pair
  typedef enum logic [1:0] {
    OPP_LVL3 = 2'h0,
    OPP_LVL2 = 2'h1,
    OPP_LVL1 = 2'h2,
    OPP_LVL0 = 2'h3
  } opp_level_t;

  // access phases
  typedef enum logic [1:0] {
    OPP_IDLE  = 2'h0,
    OPP_WRITE = 2'h1,
    OPP_READ  = 2'h2
  } opp_phase_t;

  // programmer-side pin group
  typedef struct packed {
    logic       srst_pin;
    logic       code_fetch_strobe;
    logic       code_source_select_supply_hv;
    logic       code_source_select_supply_hi;
    logic       prog_write_strobe;
    logic       prog_read_strobe;
    logic       high_address_latch_strobe;
    logic       access_select_hi;
    logic       access_select_lo;
    logic [7:0] port_two;
    logic [7:0] port_zero_in;
  } opp_pins_t;

  // protection outputs toward the core
  typedef struct packed {
    logic table_lookup_block;
    logic latch_code_source;
    logic verify2_only;
    logic verify2_block;
    logic reprog_block;
    logic ext_select_ignore;
  } opp_prot_t;

  // all module state except the memory array
  typedef struct packed {
    logic [5:0] hi_addr;
    logic       latch_prev;
    logic       wr_prev;
    logic [1:0] lock;
    logic [7:0] rd_data;
    logic       drive;
    opp_phase_t phase;
  } opp_state_t;

endpackage

//--- opp_port.sv
`timescale 1ns/1ps
`include "opp_cfg.svh"

// How it works
// - address arrives high bits first, latched by the latch strobe, then low bits held live on port two
// - write strobe triggers memory byte and lock bit programming
// - data passes both ways on port zero
// - memory byte write needs voltage, strobe, read high, select 11
// - lock write needs voltage, strobe, read high, select 10, data bits 1:0
// - identification read needs logic high supply, write high, select 01
// - two lock bits pick one of four protection levels
// - lock bit one is unprogrammed, zero is programmed
// - level 0: no locking, code source pin not latched at reset
// - level 1: lookups blocked, pin latched, verify mode 2 only, no reprogram
// - level 2: lookups blocked, pin latched, verify mode 2 reads disabled, no reprogram
// - level 3: level 2 plus pin-driven external code ignored
// - three read-only identification bytes at fc, fd, fe
// - bytes hold manufacturer, device type, stepping codes in that order
// - select 00 reserved, 01 ident, 10 lock, 11 memory byte
// - high address taken on latch strobe falling edge
// - reads happen under the read strobe
module opp_port
  import opp_pkg::*;
#(
  parameter int          ADDR_W  = `OPP_ADDR_W,
  parameter logic [7:0]  IDENT_0 = 8'h5a,  // arbitrary value
  parameter logic [7:0]  IDENT_1 = 8'h3c,  // arbitrary value
  parameter logic [7:0]  IDENT_2 = 8'h11   // arbitrary value
)
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               srst,
  // programmer pins
  input  wire opp_pins_t          pins,
  output logic [7:0]              port_zero_out,
  output logic [7:0]              port_zero_oe_n,
  // protection state toward the core
  output opp_prot_t               prot,
  output opp_level_t              level
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (ADDR_W != `OPP_ADDR_W)
    $error("opp_port: address width must be 14");

  // ************************************************************
  // memory and state
  // ************************************************************
  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0]          mem [DEPTH];
  opp_state_t          st_q;
  opp_state_t          st_d;
  logic [ADDR_W-1:0]   addr;
  logic [1:0]          sel;
  logic                prog_mode;
  logic                wr_fire;
  logic                mem_wr;
  logic                rd_active;
  logic [7:0]          rd_mux;

  // full address from latched high part and live low part
  assign sel       = {pins.access_select_hi, pins.access_select_lo};
  assign addr      = {st_q.hi_addr, pins.port_two};
  assign prog_mode = pins.srst_pin && !pins.code_fetch_strobe;
  // write fires on the strobe's falling edge with read held high
  // a strobe edge while a read is still being answered is refused
  assign wr_fire   = prog_mode && st_q.wr_prev && !pins.prog_write_strobe
                     && pins.prog_read_strobe
                     && pins.code_source_select_supply_hv
                     && (st_q.phase != OPP_READ);
  assign mem_wr    = wr_fire && (sel == `OPP_SEL_MEMORY)
                     && (st_q.lock == `OPP_LOCK_RESET);
  // read strobe low, write high, logic-high supply
  assign rd_active = prog_mode && !pins.prog_read_strobe
                     && pins.prog_write_strobe
                     && !pins.code_source_select_supply_hv
                     && pins.code_source_select_supply_hi
                     && (sel != `OPP_SEL_RESERVED);

  // read data selection per access mode
  always_comb
  begin
    rd_mux = 8'h00;
    case (sel)
      `OPP_SEL_IDENT:
      begin
        case (pins.port_two)
          `OPP_IDENT_ADDR0: rd_mux = IDENT_0;
          `OPP_IDENT_ADDR1: rd_mux = IDENT_1;
          `OPP_IDENT_ADDR2: rd_mux = IDENT_2;
          default:          rd_mux = 8'h00;
        endcase
      end
      `OPP_SEL_LOCK:   rd_mux = {6'h00, st_q.lock};
      `OPP_SEL_MEMORY:
      begin
        // reads only while verification is allowed (level 0)
        if (st_q.lock == `OPP_LOCK_RESET)
          rd_mux = mem[addr];
        else
          rd_mux = `OPP_ERASED_BYTE;
      end
      default:         rd_mux = 8'h00;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_d           = st_q;
    st_d.latch_prev = pins.high_address_latch_strobe;
    st_d.wr_prev   = pins.prog_write_strobe;
    // latch high address on falling edge of latch strobe
    if (st_q.latch_prev && !pins.high_address_latch_strobe)
      st_d.hi_addr = pins.port_two[`OPP_HI_ADDR_W-1:0];
    // lock programming only clears bits: zero means programmed
    if (wr_fire && sel == `OPP_SEL_LOCK)
      st_d.lock = st_q.lock & pins.port_zero_in[`OPP_LOCK_BIT_HI:`OPP_LOCK_BIT_LO];
    st_d.drive   = rd_active;
    st_d.rd_data = rd_active ? rd_mux : st_q.rd_data;
    case (st_q.phase)
      OPP_IDLE:  st_d.phase = rd_active ? OPP_READ : (wr_fire ? OPP_WRITE : OPP_IDLE);
      OPP_WRITE: st_d.phase = OPP_IDLE;
      OPP_READ:  st_d.phase = rd_active ? OPP_READ : OPP_IDLE;
      default:   st_d.phase = OPP_IDLE;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st_q.hi_addr   <= 6'h00;
      st_q.latch_prev <= 1'b0;
      st_q.wr_prev   <= 1'b1;
      st_q.lock      <= `OPP_LOCK_RESET;
      st_q.rd_data   <= 8'h00;
      st_q.drive     <= 1'b0;
      st_q.phase     <= OPP_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // memory array write port
  always_ff @(posedge core_clk)
  begin
    if (mem_wr)
      mem[addr] <= pins.port_zero_in;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign port_zero_out  = st_q.rd_data;
  assign port_zero_oe_n = {8{!st_q.drive}};
  assign level          = opp_level_t'(st_q.lock);

  // protection decode
  always_comb
  begin
    prot = '0;
    case (level)
      OPP_LVL0: prot = '0;
      OPP_LVL1: prot = 6'b111010;
      OPP_LVL2: prot = 6'b110110;
      OPP_LVL3: prot = 6'b110111;
      default:  prot = '0;
    endcase
  end

endmodule // opp_port

//--- opp_port_chk.sv
`timescale 1ns/1ps
// *****
// protocol checks
// *****
module opp_port_chk
  import opp_pkg::*;
#(
  parameter logic [7:0] IDENT_0 = 8'h5a,  // arbitrary value
  parameter logic [7:0] IDENT_1 = 8'h3c,  // arbitrary value
  parameter logic [7:0] IDENT_2 = 8'h11   // arbitrary value
)
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // watched ports
  input wire opp_pins_t  pins,
  input wire logic [7:0] port_zero_out,
  input wire logic [7:0] port_zero_oe_n,
  input wire opp_prot_t  prot,
  input wire opp_level_t level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [1:0] sel;
  logic       rd;
  logic [7:0] idv;
  // read condition and expected ident byte
  assign sel = {pins.access_select_hi, pins.access_select_lo};
  assign rd = !pins.prog_read_strobe && pins.prog_write_strobe && !pins.code_source_select_supply_hv
              && pins.code_source_select_supply_hi && sel != 2'h0 && pins.srst_pin && !pins.code_fetch_strobe;
  assign idv = pins.port_two == 8'hfc ? IDENT_0 : pins.port_two == 8'hfd ? IDENT_1 :
               pins.port_two == 8'hfe ? IDENT_2 : 8'h00;
  rd_drive_a: assert property (rd |=> port_zero_oe_n == 8'h00) else $error("port zero not driven");
  idle_release_a: assert property (!rd |=> port_zero_oe_n == 8'hff) else $error("port zero not released");
  ident_data_a: assert property (rd && sel == 2'h1 |=> port_zero_out == $past(idv)) else $error("bad ident");
  lock_read_a: assert property (rd && sel == 2'h2 |=> port_zero_out == {6'h00, $past(level)})
    else $error("bad lock read");
  mem_locked_a: assert property (rd && sel == 2'h3 && level != OPP_LVL0 |=> port_zero_out == 8'hff)
    else $error("locked read leaks");
  lock_clear_a: assert property (!$past(srst) |-> (level & ~$past(level)) == 2'h0) else $error("lock set");
  no_hv_hold_a: assert property (!pins.code_source_select_supply_hv [*2] |=> $stable(level))
    else $error("lock changed");
  level0_free_a: assert property (level == OPP_LVL0 |-> prot == '0) else $error("level 0 locked");
  level_prot_a: assert property (prot.reprog_block == (level != OPP_LVL0) && prot.ext_select_ignore ==
    (level == OPP_LVL3) && prot.verify2_block == !level[1] && prot.verify2_only == (level == OPP_LVL1))
    else $error("bad protection");
  ident_c: cover property (rd && sel == 2'h1);
  lock_c: cover property (rd && sel == 2'h2);
  mem_c: cover property (rd && sel == 2'h3);
  mem_wr_c: cover property ($fell(pins.prog_write_strobe) && sel == 2'h3 && pins.code_source_select_supply_hv
    && level == OPP_LVL0);
endmodule // opp_port_chk

bind opp_port opp_port_chk #(.IDENT_0(IDENT_0), .IDENT_1(IDENT_1), .IDENT_2(IDENT_2)) chk (
  .core_clk(core_clk), .srst(srst), .pins(pins), .port_zero_out(port_zero_out),
  .port_zero_oe_n(port_zero_oe_n), .prot(prot), .level(level));

//--- opp_prog_model.sv
`timescale 1ns/1ps
// *****
// programmer model
// *****
module opp_prog_model
  import opp_pkg::*;
(
  // clock
  input wire logic       core_clk,
  // device side
  input wire logic [7:0] port_zero_out,
  input wire logic [7:0] port_zero_oe_n,
  output opp_pins_t      pins
);
  opp_pins_t p;
  assign pins = p;
  // entry levels: fetch low, write strobe and supply low
  initial
  begin
    p = '0;
    p.srst_pin = 1'b1;
    p.prog_read_strobe = 1'b1;
  end
  task step;
    @(posedge core_clk);
    #1;
  endtask
  task entry;
    p.prog_write_strobe = 1'b1;
    p.code_source_select_supply_hi = 1'b1;
    step;
  endtask
  // select, latch high bits, then low bits
  task setup(input logic [1:0] s, input logic [13:0] a);
    {p.access_select_hi, p.access_select_lo} = s;
    step;
    p.high_address_latch_strobe = 1'b1;
    p.port_two = {2'h0, a[13:8]};
    step;
    p.high_address_latch_strobe = 1'b0;
    step;
    p.port_two = a[7:0];
  endtask
  task wr(input logic [1:0] s, input logic [13:0] a, input logic [7:0] dv);
    setup(s, a);
    p.port_zero_in = dv;
    p.code_source_select_supply_hv = 1'b1;
    step;
    p.prog_write_strobe = 1'b0;
    step;
    p.prog_write_strobe = 1'b1;
    p.code_source_select_supply_hv = 1'b0;
    p.port_zero_in = ~dv; // released line
    step;
  endtask
  task rd(input logic [1:0] s, input logic [13:0] a, output logic [7:0] dv);
    setup(s, a);
    p.prog_read_strobe = 1'b0;
    step;
    step;
    // a released port shows the inverse of the last value
    dv = port_zero_out ^ port_zero_oe_n;
    p.prog_read_strobe = 1'b1;
    step;
    step;
  endtask
endmodule // opp_prog_model

//--- otp_programming_port_test.sv
`timescale 1ns/1ps
// *****
// testbench
// *****
module otp_programming_port_test;
  import opp_pkg::*;
  localparam logic [7:0] ID[0:3] = '{8'h5a, 8'h3c, 8'h11, 8'h00}; // arbitrary values
  localparam logic [1:0] LV[0:3] = '{2'h2, 2'h3, 2'h1, 2'h0};
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  opp_pins_t  pins;
  opp_prot_t  prot;
  opp_level_t level;
  logic [7:0] pz_out, pz_oe_n, d;
  logic [31:0] rng = 32'he4252765;
  logic [1:0] e = 2'h3;
  int         err_total = 0;
  int         checked = 0;
  always #2.5 core_clk = ~core_clk;
  opp_port #(.IDENT_0(ID[0]), .IDENT_1(ID[1]), .IDENT_2(ID[2])) uut (.core_clk(core_clk), .srst(srst),
    .pins(pins), .port_zero_out(pz_out), .port_zero_oe_n(pz_oe_n), .prot(prot), .level(level));
  opp_prog_model pm (.core_clk(core_clk), .port_zero_out(pz_out), .port_zero_oe_n(pz_oe_n), .pins(pins));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task do_reset;
    srst = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 srst = 1'b0;
    pm.entry;
  endtask
  // level, protection outputs and lock read against lock value k
  task chk_lvl(input logic [1:0] k);
    chk({6'h00, level}, {6'h00, k});
    chk({2'h0, prot.table_lookup_block, prot.latch_code_source, prot.verify2_only,
      prot.verify2_block, prot.reprog_block, prot.ext_select_ignore},
      {2'h0, k != 2'h3, k != 2'h3, k == 2'h2, !k[1], k != 2'h3, k == 2'h0});
    pm.rd(2'h2, 14'h0000, d);
    chk(d, {6'h00, k});
  endtask
  // main sequence
  initial
  begin
    do_reset;
    chk(pz_oe_n, 8'hff);
    chk_lvl(2'h3);
    for (int i = 0; i < 4; i++)
    begin
      rng = xs(rng);
      pm.rd(2'h1, {6'h00, i < 3 ? 8'hfc + i[7:0] : {1'b0, rng[6:0]}}, d);
      chk(d, ID[i]);
    end
    pm.wr(2'h1, 14'h00fc, rng[15:8]);
    pm.rd(2'h1, 14'h00fc, d);
    chk(d, ID[0]);
    // reserved select: port stays released, so the model sees the inverse
    pm.rd(2'h0, 14'h00fc, d);
    chk(d, ~ID[0]);
    // unlocked memory bytes are written and read back
    for (int i = 0; i < 3; i++)
    begin
      rng = xs(rng);
      pm.wr(2'h3, rng[13:0], rng[23:16]);
      pm.rd(2'h3, rng[13:0], d);
      chk(d, rng[23:16]);
    end
    for (int i = 0; i < 4; i++)
    begin
      rng = xs(rng);
      if (i > 1)
      begin
        do_reset;
        e = 2'h3;
      end
      pm.wr(2'h2, rng[13:0], {rng[21:16], LV[i]});
      e &= LV[i];
      chk_lvl(e);
      pm.wr(2'h3, rng[29:16], rng[7:0]);
      pm.rd(2'h3, rng[29:16], d);
      chk(d, 8'hff);
    end
    finish_test;
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    finish_test;
  end
endmodule // otp_programming_port_test
